// [logic/irs_avg.sv]
// power-of-two sample averager for one temperature channel
// assumes samples arrive as single-cycle strobes on the core clock

`timescale 1ns/1ps
`default_nettype none

module irs_avg #(
	parameter int unsigned W     = 16,
	parameter int unsigned CNT_W = 12
) (
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic                clear,
	input  wire logic                in_vld,
	input  wire logic signed [W-1:0] in_data,
	input  wire logic [3:0]          shift,
	output logic signed [W-1:0]      avg,
	output logic                     done
);
	logic signed [W+CNT_W-1:0] acc_q;
	logic [CNT_W-1:0]          cnt_q;
	logic [CNT_W-1:0]          target;
	logic signed [W+CNT_W-1:0] acc_sh;

	assign target = CNT_W'(1) << shift;
	assign done   = (cnt_q == target);
	// sum is exact, so an arithmetic shift gives the mean rounded down
	assign acc_sh = acc_q >>> shift;
	assign avg    = acc_sh[W-1:0];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_q <= '0;
			cnt_q <= '0;
		end else if (clear) begin
			acc_q <= '0;
			cnt_q <= '0;
		end else if (in_vld && !done) begin
			acc_q <= acc_q + {{CNT_W{in_data[W-1]}}, in_data};
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end
endmodule

`default_nettype wire

// [logic/irs_mode_seq.sv]
// operating-mode sequencer of an infrared temperature sensor
// assumes an analog front end that strobes raw samples while enabled
// and an algorithm engine that reports three event flags

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1 - three modes: power-down, one-shot, continuous
// RULE2 - ambient averaging code picks 8, 4, 2, 1
// RULE3 - object averaging code picks 2 to 2048
// RULE4 - outputs hold averaged values in every mode
// RULE5 - after boot device sits in power-down
// RULE6 - power-down stops acquisition, serial port alive
// RULE7 - power-down keeps config and last outputs
// RULE8 - rate code zero means power-down
// RULE9 - host drains data-ready before stopping continuous
// RULE10 - reading event flags clears data-ready
// RULE11 - host triggers one-shot only from power-down
// RULE12 - one-shot acquires once, self-clears trigger
// RULE13 - host keeps rate zero in one-shot use
// RULE14 - conversion time follows object averaging code
// RULE15 - host respects one-shot maximum trigger rate
// RULE16 - one-shot skips detection algorithms
// RULE17 - continuous refreshes outputs once per period
// RULE18 - nonzero rate starts sampling at coded rate
// RULE19 - data-ready sets on new set, sticky
// RULE20 - too-fast rate clamps to fastest allowed
// RULE21 - one-shot completion also sets data-ready
// RULE22 - output set updates as one coherent unit
module irs_mode_seq #(
	parameter int unsigned W            = 16,
	parameter int unsigned CONV_CYC [8] = irs_pkg::CONV_CYC_DEF,
	parameter int unsigned ODR_CYC  [8] = irs_pkg::ODR_CYC_DEF
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         spc,
	input  wire logic         spi_cs_b,
	input  wire logic         sdio_i,
	output logic              sdio_o,
	output logic              sdio_oe_b,
	output logic              fe_enable,
	input  wire logic         sample_vld,
	input  wire logic [W-1:0] obj_raw,
	input  wire logic [W-1:0] amb_raw,
	output logic              algo_run,
	input  wire logic [2:0]   algo_events
);
	// ****************************************
	// serial register port
	// ****************************************
	irs_reg_if bus ();

	irs_spi_slave u_spi (
		.clk       (clk),
		.rst_b     (rst_b),
		.spc       (spc),
		.spi_cs_b  (spi_cs_b),
		.sdio_i    (sdio_i),
		.sdio_o    (sdio_o),
		.sdio_oe_b (sdio_oe_b),
		.bus       (bus.master)
	);

	// ****************************************
	// configuration registers
	// ****************************************
	logic [7:0] avg_cfg_q;
	logic [7:0] rate_q;
	logic [7:0] mode_ctl_q;
	logic       oneshot_q;
	logic       new_sample_flag_q;
	logic       wr_avg;
	logic       wr_rate;
	logic       wr_mode;
	logic       rd_algo;

	assign wr_avg  = bus.wr && bus.addr == irs_pkg::ADDR_AVG_CFG;
	assign wr_rate = bus.wr && bus.addr == irs_pkg::ADDR_RATE;
	assign wr_mode = bus.wr && bus.addr == irs_pkg::ADDR_MODE;
	assign rd_algo = bus.rd && bus.addr == irs_pkg::ADDR_ALGO;

	// held in every mode; only the host changes them
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avg_cfg_q  <= irs_pkg::AVG_CFG_RST; // [RULE2] [RULE3]
			rate_q     <= irs_pkg::RATE_RST; // [RULE5]
			mode_ctl_q <= irs_pkg::MODE_RST;
		end else begin
			if (wr_avg) begin
				avg_cfg_q <= bus.wdata; // [RULE7]
			end
			if (wr_rate) begin
				rate_q <= bus.wdata;
			end
			if (wr_mode) begin
				mode_ctl_q <= bus.wdata;
			end
		end
	end

	logic [2:0] obj_sel;
	logic [1:0] amb_sel;
	logic [3:0] rate_code;
	logic [3:0] req_code;
	logic [3:0] max_code;
	logic [3:0] eff_code;
	logic       odr_zero;

	assign obj_sel   = avg_cfg_q[irs_pkg::OBJ_AVG_LSB +: 3];
	assign amb_sel   = avg_cfg_q[irs_pkg::AMB_AVG_LSB +: 2];
	assign rate_code = rate_q[irs_pkg::ODR_LSB +: 4];
	assign odr_zero  = (rate_code == 4'h0); // [RULE8]
	// any code with the top bit set selects the fastest rate
	assign req_code  = rate_code[3] ? irs_pkg::ODR_FASTEST : rate_code;
	assign max_code  = irs_pkg::ODR_MAX_CODE[obj_sel];
	assign eff_code  = (req_code > max_code) ? max_code : req_code; // [RULE20]

	// ****************************************
	// mode sequencing
	// ****************************************
	irs_pkg::irs_mode_t mode_q;
	irs_pkg::irs_mode_t mode_d;
	logic               acq_busy_q;
	logic               acq_start;
	logic               acq_done;
	logic               publish;
	logic               oneshot_end;
	logic [31:0]        conv_cnt_q;
	logic [31:0]        per_cnt_q;
	logic               obj_done;
	logic               amb_done;

	assign acq_done = acq_busy_q && conv_cnt_q == 32'h0 &&
		obj_done && amb_done;

	always_comb begin
		mode_d    = mode_q;
		acq_start = 1'b0;
		case (mode_q)
			irs_pkg::MODE_PD: begin
				if (!odr_zero) begin
					mode_d    = irs_pkg::MODE_CONT; // [RULE18]
					acq_start = 1'b1;
				end else if (oneshot_q) begin
					mode_d    = irs_pkg::MODE_ONE; // [RULE1]
					acq_start = 1'b1;
				end
			end
			irs_pkg::MODE_ONE: begin
				// a single set, then back to rest
				if (acq_done) begin
					mode_d = irs_pkg::MODE_PD; // [RULE12]
				end
			end
			irs_pkg::MODE_CONT: begin
				if (odr_zero) begin
					mode_d = irs_pkg::MODE_PD; // [RULE8]
				end else if (per_cnt_q == 32'h0) begin
					acq_start = 1'b1; // [RULE17]
				end
			end
			default: begin
				mode_d = irs_pkg::MODE_PD;
			end
		endcase
	end

	// a set cut short by leaving continuous mode is dropped
	assign publish = acq_done &&
		!(mode_q == irs_pkg::MODE_CONT && odr_zero); // [RULE7]
	assign oneshot_end = acq_done && mode_q == irs_pkg::MODE_ONE;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= irs_pkg::MODE_PD; // [RULE5]
		end else begin
			mode_q <= mode_d;
		end
	end

	// period timer; rate changes take effect at the next period
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			per_cnt_q <= '0;
		end else if (acq_start) begin
			per_cnt_q <= ODR_CYC[3'(eff_code - 4'h1)] - 32'h1; // [RULE18]
		end else if (per_cnt_q != 32'h0) begin
			per_cnt_q <= per_cnt_q - 32'h1;
		end
	end

	// conversion timer and front-end power
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acq_busy_q <= 1'b0;
			conv_cnt_q <= '0;
		end else if (acq_start) begin
			acq_busy_q <= 1'b1;
			conv_cnt_q <= CONV_CYC[obj_sel] - 32'h1; // [RULE14]
		end else if (acq_done || mode_d == irs_pkg::MODE_PD) begin
			acq_busy_q <= 1'b0; // [RULE6]
		end else if (conv_cnt_q != 32'h0) begin
			conv_cnt_q <= conv_cnt_q - 32'h1;
		end
	end

	assign fe_enable = acq_busy_q; // [RULE6]
	assign algo_run  = (mode_q == irs_pkg::MODE_CONT); // [RULE16]

	// trigger bit: a host write beats the self-clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			oneshot_q <= 1'b0;
		end else if (wr_mode) begin
			oneshot_q <= bus.wdata[irs_pkg::ONESHOT_BIT];
		end else if (oneshot_end) begin
			oneshot_q <= 1'b0; // [RULE12]
		end
	end

	// ****************************************
	// averaging and output registers
	// ****************************************
	logic signed [W-1:0] obj_avg;
	logic signed [W-1:0] amb_avg;
	logic                take;

	assign take = sample_vld && acq_busy_q;

	irs_avg #(.W(W)) u_obj_avg (
		.clk     (clk),
		.rst_b   (rst_b),
		.clear   (acq_start),
		.in_vld  (take),
		.in_data (obj_raw),
		.shift   (irs_pkg::OBJ_AVG_SHIFT[obj_sel]), // [RULE3]
		.avg     (obj_avg),
		.done    (obj_done)
	);

	irs_avg #(.W(W)) u_amb_avg (
		.clk     (clk),
		.rst_b   (rst_b),
		.clear   (acq_start),
		.in_vld  (take),
		.in_data (amb_raw),
		.shift   (irs_pkg::AMB_AVG_SHIFT[amb_sel]), // [RULE2]
		.avg     (amb_avg),
		.done    (amb_done)
	);

	logic [W-1:0] obj_out_q;
	logic [W-1:0] amb_out_q;
	logic [7:0]   obj_hi_q;
	logic [7:0]   amb_hi_q;

	// both channels land in the same edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			obj_out_q <= '0;
			amb_out_q <= '0;
		end else if (publish) begin
			obj_out_q <= obj_avg; // [RULE4] [RULE22]
			amb_out_q <= amb_avg; // [RULE22]
		end
	end

	// low-byte read freezes the high byte so a pair never mixes sets
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			obj_hi_q <= '0;
			amb_hi_q <= '0;
		end else if (bus.rd) begin
			if (bus.addr == irs_pkg::ADDR_OBJ_L) begin
				obj_hi_q <= obj_out_q[15:8]; // [RULE22]
			end
			if (bus.addr == irs_pkg::ADDR_AMB_L) begin
				amb_hi_q <= amb_out_q[15:8];
			end
		end
	end

	// data-ready: a new set beats a clearing read in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			new_sample_flag_q <= 1'b0;
		end else if (publish) begin
			new_sample_flag_q <= 1'b1; // [RULE19] [RULE21]
		end else if (rd_algo) begin
			new_sample_flag_q <= 1'b0; // [RULE10]
		end
	end

	// ****************************************
	// read data
	// ****************************************
	always_comb begin
		bus.rdata = 8'h00;
		case (bus.addr)
			irs_pkg::ADDR_AVG_CFG: bus.rdata = avg_cfg_q;
			irs_pkg::ADDR_RATE:    bus.rdata = rate_q;
			irs_pkg::ADDR_MODE: begin
				bus.rdata = mode_ctl_q;
				bus.rdata[irs_pkg::ONESHOT_BIT] = oneshot_q;
			end
			irs_pkg::ADDR_STATUS: begin
				bus.rdata[irs_pkg::NEW_SAMPLE_FLAG_BIT] = new_sample_flag_q;
			end
			irs_pkg::ADDR_ALGO:  bus.rdata = {5'h00, algo_events};
			irs_pkg::ADDR_OBJ_L: bus.rdata = obj_out_q[7:0];
			irs_pkg::ADDR_OBJ_H: bus.rdata = obj_hi_q;
			irs_pkg::ADDR_AMB_L: bus.rdata = amb_out_q[7:0];
			irs_pkg::ADDR_AMB_H: bus.rdata = amb_hi_q;
			default:             bus.rdata = 8'h00;
		endcase
	end
endmodule

`default_nettype wire

// [logic/irs_pkg.sv]
// constants shared by the ir sensor mode sequencer modules
// assumes a single 40 MHz core clock; times are converted here

package irs_pkg;

	// ****************************************
	// clock and time conversion
	// ****************************************
	localparam int unsigned CLK_HZ     = 40_000_000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

	// ****************************************
	// register offsets (7-bit serial address)
	// ****************************************
	localparam logic [6:0] ADDR_AVG_CFG = 7'h10;
	localparam logic [6:0] ADDR_RATE    = 7'h20;
	localparam logic [6:0] ADDR_MODE    = 7'h21;
	localparam logic [6:0] ADDR_STATUS  = 7'h23;
	localparam logic [6:0] ADDR_ALGO    = 7'h25;
	localparam logic [6:0] ADDR_OBJ_L   = 7'h26;
	localparam logic [6:0] ADDR_OBJ_H   = 7'h27;
	localparam logic [6:0] ADDR_AMB_L   = 7'h28;
	localparam logic [6:0] ADDR_AMB_H   = 7'h29;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int unsigned OBJ_AVG_LSB = 0;
	localparam int unsigned AMB_AVG_LSB = 4;
	localparam int unsigned ODR_LSB     = 0;
	localparam int unsigned ONESHOT_BIT = 0;
	localparam int unsigned NEW_SAMPLE_FLAG_BIT    = 2;
	localparam int unsigned SPI_RW_BIT  = 7;
	localparam logic [7:0] AVG_CFG_RST  = 8'h03;
	localparam logic [7:0] RATE_RST     = 8'h00;
	localparam logic [7:0] MODE_RST     = 8'h00;
	localparam logic [3:0] ODR_FASTEST  = 4'h8;

	// pin order in the synchroniser: cs, spc, sdi
	localparam int unsigned PIN_CS  = 0;
	localparam int unsigned PIN_SPC = 1;
	localparam int unsigned PIN_SDI = 2;
	localparam logic [2:0] PIN_RST  = 3'h3;

	// ****************************************
	// averaging and rate tables
	// ****************************************
	localparam logic [3:0] OBJ_AVG_SHIFT [8] = '{4'h1, 4'h3, 4'h5, 4'h7,
		4'h8, 4'h9, 4'hA, 4'hB};
	localparam logic [3:0] AMB_AVG_SHIFT [4] = '{4'h3, 4'h2, 4'h1, 4'h0};
	localparam logic [3:0] ODR_MAX_CODE  [8] = '{4'h8, 4'h8, 4'h8, 4'h6,
		4'h5, 4'h4, 4'h3, 4'h2};

	localparam int unsigned CONV_TIME_US [8] = '{5500, 6300, 9100, 20700,
		36100, 67000, 128600, 252000};
	// indexed by rate code minus one
	localparam int unsigned ODR_PERIOD_US [8] = '{4000000, 2000000,
		1000000, 500000, 250000, 126000, 66670, 33330};

	localparam int unsigned CONV_CYC_DEF [8] = '{
		CONV_TIME_US[0] * CYC_PER_US, CONV_TIME_US[1] * CYC_PER_US,
		CONV_TIME_US[2] * CYC_PER_US, CONV_TIME_US[3] * CYC_PER_US,
		CONV_TIME_US[4] * CYC_PER_US, CONV_TIME_US[5] * CYC_PER_US,
		CONV_TIME_US[6] * CYC_PER_US, CONV_TIME_US[7] * CYC_PER_US};
	localparam int unsigned ODR_CYC_DEF [8] = '{
		ODR_PERIOD_US[0] * CYC_PER_US, ODR_PERIOD_US[1] * CYC_PER_US,
		ODR_PERIOD_US[2] * CYC_PER_US, ODR_PERIOD_US[3] * CYC_PER_US,
		ODR_PERIOD_US[4] * CYC_PER_US, ODR_PERIOD_US[5] * CYC_PER_US,
		ODR_PERIOD_US[6] * CYC_PER_US, ODR_PERIOD_US[7] * CYC_PER_US};

	typedef enum logic [1:0] {
		MODE_PD,
		MODE_ONE,
		MODE_CONT
	} irs_mode_t;

endpackage

// [logic/irs_reg_if.sv]
// register access strobes between the serial slave and the sequencer
// assumes both ends run on the same core clock

`timescale 1ns/1ps
`default_nettype none

interface irs_reg_if;
	logic       rd;
	logic       wr;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport master (
		output rd,
		output wr,
		output addr,
		output wdata,
		input  rdata
	);
	modport slave (
		input  rd,
		input  wr,
		input  addr,
		input  wdata,
		output rdata
	);
endinterface

`default_nettype wire

// [logic/irs_spi_slave.sv]
// 3-wire serial register port: command byte then data bytes, msb first
// assumes spc idles high; pins are asynchronous to clk

`timescale 1ns/1ps
`default_nettype none

module irs_spi_slave (
	input  wire logic     clk,
	input  wire logic     rst_b,
	input  wire logic     spc,
	input  wire logic     spi_cs_b,
	input  wire logic     sdio_i,
	output logic          sdio_o,
	output logic          sdio_oe_b,
	irs_reg_if.master     bus
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] pin_raw;
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] s3_q;
	logic [2:0] filt_q;
	logic [2:0] prev_q;

	assign pin_raw = {sdio_i, spc, spi_cs_b};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			// a level counts only once stage two and three agree
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					s1_q[gi]   <= irs_pkg::PIN_RST[gi];
					s2_q[gi]   <= irs_pkg::PIN_RST[gi];
					s3_q[gi]   <= irs_pkg::PIN_RST[gi];
					filt_q[gi] <= irs_pkg::PIN_RST[gi];
					prev_q[gi] <= irs_pkg::PIN_RST[gi];
				end else begin
					s1_q[gi]   <= pin_raw[gi];
					s2_q[gi]   <= s1_q[gi];
					s3_q[gi]   <= s2_q[gi];
					prev_q[gi] <= filt_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						filt_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	logic cs_act;
	logic spc_rise;
	logic spc_fall;
	logic sdi;

	assign cs_act   = ~filt_q[irs_pkg::PIN_CS];
	assign spc_rise = filt_q[irs_pkg::PIN_SPC] & ~prev_q[irs_pkg::PIN_SPC];
	assign spc_fall = ~filt_q[irs_pkg::PIN_SPC] & prev_q[irs_pkg::PIN_SPC];
	assign sdi      = filt_q[irs_pkg::PIN_SDI];

	// ****************************************
	// frame state
	// ****************************************
	logic [2:0] bit_q;
	logic       cmd_q;
	logic       rw_q;
	logic [6:0] addr_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic       oe_q;
	logic [7:0] rx_d;

	assign rx_d      = {rx_q[6:0], sdi};
	assign bus.addr  = addr_q;
	assign bus.wdata = rx_d;
	assign bus.wr    = cs_act & spc_rise & cmd_q & ~rw_q & (bit_q == 3'h7);
	// fetch lazily on the falling edge so no byte past the last is read
	assign bus.rd    = cs_act & spc_fall & cmd_q & rw_q & (bit_q == 3'h0);
	assign sdio_o    = tx_q[7];
	assign sdio_oe_b = ~oe_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_q <= '0;
			cmd_q <= 1'b0;
			rw_q  <= 1'b0;
			rx_q  <= '0;
		end else if (!cs_act) begin
			bit_q <= '0;
			cmd_q <= 1'b0;
		end else if (spc_rise) begin
			rx_q  <= rx_d;
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7 && !cmd_q) begin
				cmd_q <= 1'b1;
				rw_q  <= rx_d[irs_pkg::SPI_RW_BIT];
			end
		end
	end

	// auto-increment after every data byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_q <= '0;
		end else if (cs_act && spc_rise && bit_q == 3'h7 && !cmd_q) begin
			addr_q <= rx_d[6:0];
		end else if (bus.wr || bus.rd) begin
			addr_q <= addr_q + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_q <= '0;
			oe_q <= 1'b0;
		end else if (!cs_act) begin
			oe_q <= 1'b0;
		end else if (bus.rd) begin
			tx_q <= bus.rdata;
			oe_q <= 1'b1;
		end else if (spc_fall && cmd_q && rw_q) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end
endmodule

`default_nettype wire

// [sim/irs_host.sv]
// host model on the 3-wire serial port, one data byte per frame
// assumes spc idles high and the device shifts on falling spc
`timescale 1ns/1ps
`default_nettype none

module irs_host (
	output logic      spc,
	output logic      spi_cs_b,
	output logic      host_dat,
	input  wire logic sdio_line
);
	initial begin
		spc = 1'b1;
		spi_cs_b = 1'b1;
		host_dat = 1'b0;
	end

	// read bits taken late in the high phase: the device answers
	// several core clocks after each fall
	task automatic access(
		input  logic [7:0] cmd,
		input  logic [7:0] wd,
		output logic [7:0] rd
	);
		logic [15:0] sh;
		sh = {cmd, wd};
		rd = 8'h00;
		#7;
		spi_cs_b = 1'b0;
		#100;
		for (int i = 15; i >= 0; i--) begin
			spc = 1'b0;
			// released line toggles, a stale level never reads back
			if (i > 7 || !cmd[7])
				host_dat = sh[i];
			else
				host_dat = ~host_dat;
			#100;
			spc = 1'b1;
			#95;
			rd = {rd[6:0], sdio_line};
			#5;
		end
		#200;
		spi_cs_b = 1'b1;
		host_dat = ~host_dat;
		#400;
	endtask
endmodule

`default_nettype wire

// [sim/irs_mode_seq_assertions.sv]
// checker on the mode sequencer top ports
// assumes one clk domain with async active-low reset
`timescale 1ns/1ps
`default_nettype none

module irs_mode_seq_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic spi_cs_b,
	input wire logic sdio_oe_b,
	input wire logic fe_enable,
	input wire logic algo_run
);
	// cycles of one-shot acquisition, ceiling 12'h834
	logic [11:0] acq_cnt_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			acq_cnt_q <= '0;
		else if (!fe_enable || algo_run)
			acq_cnt_q <= '0;
		else
			acq_cnt_q <= acq_cnt_q + 12'h001;
	end

	property p_boot_pd;
		$rose(rst_b) |-> !fe_enable && !algo_run && sdio_oe_b;
	endproperty
	a_boot_pd: assert property (p_boot_pd)
		else $error("not idle after reset");

	property p_cs_quiet;
		spi_cs_b [*8] |-> sdio_oe_b;
	endproperty
	a_cs_quiet: assert property (p_cs_quiet)
		else $error("data pin driven while deselected");

	property p_no_early_drive;
		$fell(spi_cs_b) |-> sdio_oe_b [*8];
	endproperty
	a_no_early_drive: assert property (p_no_early_drive)
		else $error("data pin driven during command byte");

	property p_cont_starts;
		$rose(algo_run) |-> ##[0:2] fe_enable;
	endproperty
	a_cont_starts: assert property (p_cont_starts)
		else $error("continuous start without acquisition");

	property p_pd_stops;
		$fell(algo_run) |-> ##2 (!fe_enable) [*8];
	endproperty
	a_pd_stops: assert property (p_pd_stops)
		else $error("acquisition after rate cleared");

	property p_mode_by_host;
		$changed(algo_run) |-> !spi_cs_b;
	endproperty
	a_mode_by_host: assert property (p_mode_by_host)
		else $error("mode changed outside a host frame");

	property p_oneshot_no_algo;
		$rose(fe_enable) ##2 !algo_run |-> !algo_run until !fe_enable;
	endproperty
	a_oneshot_no_algo: assert property (p_oneshot_no_algo)
		else $error("detection enabled in one-shot");

	property p_acq_bounded;
		acq_cnt_q < 12'h834;
	endproperty
	a_acq_bounded: assert property (p_acq_bounded)
		else $error("one-shot never returned to power-down");
endmodule

`default_nettype wire

// [sim/irs_mode_seq_tb.sv]
// self-checking bench for the ir sensor mode sequencer
// assumes the host model on the pins and a steady front end
`timescale 1ns/1ps
`default_nettype none

bind irs_mode_seq irs_mode_seq_chk i_irs_mode_seq_chk (
	.clk       (clk),
	.rst_b     (rst_b),
	.spi_cs_b  (spi_cs_b),
	.sdio_oe_b (sdio_oe_b),
	.fe_enable (fe_enable),
	.algo_run  (algo_run)
);

module irs_mode_seq_tb;
	// short counts so every mode fits one run
	localparam int unsigned CONV_T [8] = '{8{200}};
	localparam int unsigned ODR_T  [8] = '{9000, 8000, 7000, 6000,
		5000, 4000, 3000, 2000};
	logic        clk;
	logic        rst_b;
	logic        spc;
	logic        spi_cs_b;
	logic        host_dat;
	logic        sdio_line;
	logic        sdio_o;
	logic        sdio_oe_b;
	logic        fe_enable;
	logic        sample_vld = 1'b1;
	logic [15:0] obj_raw = 16'h0064;
	logic [15:0] amb_raw = 16'h0123;
	logic        algo_run;
	logic [2:0]  algo_events = 3'h5;
	logic        fe_prev = 1'b0;
	int          num_errors = 0;
	int          compares = 0;
	int          cyc = 0;
	int          fe_rise = 0;
	int          fe_gap = 0;

	assign sdio_line = !sdio_oe_b ? sdio_o : host_dat;

	irs_mode_seq #(
		.W        (16),
		.CONV_CYC (CONV_T),
		.ODR_CYC  (ODR_T)
	) i_irs_mode_seq (
		.clk         (clk),
		.rst_b       (rst_b),
		.spc         (spc),
		.spi_cs_b    (spi_cs_b),
		.sdio_i      (sdio_line),
		.sdio_o      (sdio_o),
		.sdio_oe_b   (sdio_oe_b),
		.fe_enable   (fe_enable),
		.sample_vld  (sample_vld),
		.obj_raw     (obj_raw),
		.amb_raw     (amb_raw),
		.algo_run    (algo_run),
		.algo_events (algo_events)
	);

	irs_host i_irs_host (
		.spc       (spc),
		.spi_cs_b  (spi_cs_b),
		.host_dat  (host_dat),
		.sdio_line (sdio_line)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// object samples alternate 100 and 300, so any even count gives 200
	always @(negedge clk) begin
		obj_raw <= (obj_raw === 16'h0064) ? 16'h012C : 16'h0064;
		cyc <= cyc + 1;
		fe_prev <= fe_enable;
		if (fe_enable === 1'b1 && fe_prev === 1'b0) begin
			fe_gap <= cyc - fe_rise;
			fe_rise <= cyc;
		end
		if (cyc == 90000) begin
			num_errors++;
			stop_test();
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic stop_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		@(negedge clk);
		i_irs_host.access({1'b0, a}, d, r);
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk);
		i_irs_host.access({1'b1, a}, 8'h00, d);
	endtask

	task automatic rchk(input logic [6:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		check({24'h0, d & m}, {24'h0, e});
	endtask

	task automatic wait_ready;
		logic [7:0] d;
		d = 8'h00;
		for (int n = 0; n < 40 && d[2] !== 1'b1; n++)
			rd(irs_pkg::ADDR_STATUS, d);
		check({24'h0, d & 8'h04}, 32'h4);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_values;
		rchk(irs_pkg::ADDR_AVG_CFG, 8'hFF, 8'h03);
		rchk(irs_pkg::ADDR_RATE, 8'hFF, 8'h00);
		rchk(irs_pkg::ADDR_MODE, 8'hFF, 8'h00);
		wr(irs_pkg::ADDR_STATUS, 8'hFF);
		rchk(irs_pkg::ADDR_STATUS, 8'hFF, 8'h00);
		rchk(7'h30, 8'hFF, 8'h00);
		check({31'h0, fe_enable}, 32'h0);
	endtask

	task automatic one_shot(input logic [7:0] cfg);
		logic [7:0] d;
		wr(irs_pkg::ADDR_AVG_CFG, cfg);
		wr(irs_pkg::ADDR_MODE, 8'h01);
		if (cfg[2:0] == 3'h7)
			check({30'h0, fe_enable, algo_run}, 32'h2);
		wait_ready();
		rchk(irs_pkg::ADDR_MODE, 8'h01, 8'h00);
		rchk(irs_pkg::ADDR_OBJ_L, 8'hFF, 8'hC8);
		rchk(irs_pkg::ADDR_OBJ_H, 8'hFF, 8'h00);
		rchk(irs_pkg::ADDR_AMB_L, 8'hFF, 8'h23);
		rchk(irs_pkg::ADDR_AMB_H, 8'hFF, 8'h01);
		rchk(irs_pkg::ADDR_ALGO, 8'h07, 8'h05);
		rchk(irs_pkg::ADDR_STATUS, 8'h04, 8'h00);
		rchk(irs_pkg::ADDR_AVG_CFG, 8'hFF, cfg);
	endtask

	task automatic t_averaging;
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			one_shot({2'b00, c[1:0], 1'b0, c});
		end
	endtask

	// sampling period read from acquisition starts
	task automatic period(input int unsigned exp);
		repeat (3 * exp) @(negedge clk);
		check(fe_gap, exp);
	endtask

	task automatic t_continuous;
		logic [7:0] d;
		wr(irs_pkg::ADDR_AVG_CFG, 8'h30);
		wr(irs_pkg::ADDR_RATE, 8'h08);
		check({31'h0, algo_run}, 32'h1);
		period(ODR_T[7]);
		rd(irs_pkg::ADDR_ALGO, d);
		wait_ready();
		wr(irs_pkg::ADDR_RATE, 8'h00);
		rd(irs_pkg::ADDR_ALGO, d);
		rchk(irs_pkg::ADDR_STATUS, 8'h04, 8'h00);
		repeat (3000) @(negedge clk);
		check({30'h0, fe_enable, algo_run}, 32'h0);
		rchk(irs_pkg::ADDR_STATUS, 8'h04, 8'h00);
		rchk(irs_pkg::ADDR_OBJ_L, 8'hFF, 8'hC8);
		// object code 4 allows rate code 5 at most
		wr(irs_pkg::ADDR_AVG_CFG, 8'h34);
		wr(irs_pkg::ADDR_RATE, 8'h08);
		period(ODR_T[4]);
		wr(irs_pkg::ADDR_RATE, 8'h00);
		// a plain code one below the fastest, within the limit of object code 0
		wr(irs_pkg::ADDR_AVG_CFG, 8'h30);
		wr(irs_pkg::ADDR_RATE, 8'h07);
		check({31'h0, algo_run}, 32'h1);
		period(ODR_T[6]);
		wr(irs_pkg::ADDR_RATE, 8'h00);
		wr(irs_pkg::ADDR_AVG_CFG, 8'h34);
		rchk(irs_pkg::ADDR_AVG_CFG, 8'hFF, 8'h34);
	endtask

	initial begin
		rst_b = 1'b0;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		t_reset_values();
		t_averaging();
		t_continuous();
		stop_test();
	end
endmodule

`default_nettype wire
